// *** core/lsi_pkg.sv ***
// package: register codes, address bytes, reset values and timing counts
// assumes a 50 MHz system clock on both ends
package lsi_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam logic [6:0] ADDR_VARIANT_A = 7'h29;
  localparam logic [6:0] ADDR_VARIANT_B = 7'h10;
  localparam logic [7:0] CODE_CONFIG_PRIMARY = 8'h00;
  localparam logic [7:0] CODE_CONFIG_SECONDARY = 8'h01;
  localparam logic [7:0] CODE_UPPER_LOW = 8'h04;
  localparam logic [7:0] CODE_UPPER_HIGH = 8'h05;
  localparam logic [7:0] CODE_LOWER_LOW = 8'h06;
  localparam logic [7:0] CODE_LOWER_HIGH = 8'h07;
  localparam logic [7:0] CODE_VISIBLE_LOW = 8'h10;
  localparam logic [7:0] CODE_VISIBLE_HIGH = 8'h11;
  localparam logic [7:0] CODE_INFRARED_LOW = 8'h12;
  localparam logic [7:0] CODE_INFRARED_HIGH = 8'h13;
  localparam logic [7:0] CODE_PART_LOW = 8'h14;
  localparam logic [7:0] CODE_PART_HIGH = 8'h15;
  localparam logic [7:0] CODE_EVENT_FLAGS = 8'h17;
  localparam logic [7:0] CODE_LAST = 8'h17;
  localparam logic [7:0] RST_CONFIG_PRIMARY = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam int BIT_CORE_POWER_DOWN = 0;
  localparam int BIT_CHANNEL_POWER_DOWN = 7;
  localparam int BIT_FORCED_RESULT_READY = 3;
  localparam int BIT_LOW_CROSSING = 2;
  localparam int BIT_HIGH_CROSSING = 1;
  localparam logic [7:0] EVENT_MASK = 8'h0E;
  // bus timeout, least figure rounds up
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  // host bit timing: quarter period of a 100 kHz bus
  localparam int SCL_KHZ = 100;
  localparam int QUARTER_CYC = (CLK_HZ / (SCL_KHZ * 1000) + 3) / 4;
  // wishbone register offsets of the controller
  localparam logic [3:0] WB_CTRL = 4'h0;
  localparam logic [3:0] WB_STATUS = 4'h4;
  localparam logic [3:0] WB_DATA = 4'h8;
  typedef enum logic [1:0] {LSI_OP_WRITE, LSI_OP_READ} lsi_op_e;
endpackage

// *** core/lsi_bus_if.sv ***
// interface: the two-wire bus and interrupt line between host and sensor
// assumes pull-ups: a wire is low when any enable is low
`timescale 1ns/1ps
interface lsi_bus_if;
  logic scl_oe_n_host;
  logic sda_oe_n_host;
  logic sda_oe_n_dev;
  logic int_oe_n_dev;
  logic scl;
  logic sda;
  logic int_line;
  assign scl = scl_oe_n_host;
  assign sda = sda_oe_n_host & sda_oe_n_dev;
  assign int_line = int_oe_n_dev;
  modport device (input scl, input sda, output sda_oe_n_dev, output int_oe_n_dev);
  modport host (input scl, input sda, input int_line, output scl_oe_n_host,
                output sda_oe_n_host);
endinterface

// *** core/lsi_sync.sv ***
// module: two-stage synchroniser for pin levels
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module lsi_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stage_reg <= '1;
      sync_out <= '1;
    end
    else
    begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule

// *** core/lsi_sensor.sv ***
// What this block does
// - first variant answers only at 7-bit address 0x29
// - address low bit: 0 write, 1 read
// - second variant answers at address 0x10
// - command byte selects the register
// - decode codes to 0x17, reserved read zero
// - host writes both configuration registers together
// - shutdown keeps last results
// - reads still answered while shut down
// - visible result low 0x10, high 0x11
// - infrared result low 0x12, high 0x13
// - upper threshold at 0x04 and 0x05
// - lower threshold at 0x06 and 0x07
// - event flags at 0x17, zero after reset
// - identification bytes at 0x14 and 0x15
// - works from 10 kHz to 400 kHz
// - line low 25 ms releases bus state
// - interrupt output is open drain
// - primary bit 0 shutdown, resets to 1
// - secondary bit 7 powers channels down
// - event bits 3,2,1 ready, low, high
// file: sensor end, I2C target with register file
// assumes results and events come from the measurement core as inputs
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module lsi_sensor
  import lsi_pkg::*;
#(
  parameter bit ADDR_VARIANT = 1'b0,
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter logic [7:0] PART_LOW = 8'hA5,  // arbitrary identity value
  parameter logic [7:0] PART_HIGH = 8'h30  // arbitrary identity value
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus
  lsi_bus_if.device bus,
  // measurement core
  input wire logic result_valid,
  input wire logic [15:0] visible_in,
  input wire logic [15:0] infrared_in,
  input wire logic [2:0] event_set,
  input wire logic event_clear,
  input wire logic int_request,
  // power controls
  output logic core_power_down,
  output logic channel_power_down,
  output logic [7:0] config_primary,
  output logic [7:0] config_secondary
);
  import lsi_pkg::*;
  typedef enum {LSI_IDLE, LSI_ADDR, LSI_ACK, LSI_WRX, LSI_RDX, LSI_RACK} lsi_state_e;
  lsi_state_e state_reg;
  logic [1:0] pin_sync;
  logic scl_s, sda_s, scl_d, sda_d;
  logic start_det, stop_det, scl_rise, scl_fall;
  logic [7:0] shift_reg, code_reg, rdata;
  logic [3:0] bit_reg;
  logic rw_reg, have_code_reg, sda_oe_n_reg, time_out;
  logic [7:0] upper_lo, upper_hi, lower_lo, lower_hi, events_reg;
  logic [15:0] visible_reg, infrared_reg;
  logic [31:0] low_cnt_reg;
  logic [6:0] my_addr;
  lsi_sync #(.WIDTH(2)) u_sync (.clk(clk), .sys_rst(sys_rst),
    .async_in({bus.scl, bus.sda}), .sync_out(pin_sync));
  assign scl_s = pin_sync[1];
  assign sda_s = pin_sync[0];
  assign my_addr = ADDR_VARIANT ? ADDR_VARIANT_B : ADDR_VARIANT_A;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  // edge sampling on the system clock covers the whole bus rate range
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  // stuck-low timeout
  always_ff @(posedge clk)
  begin
    if (sys_rst || (scl_s && sda_s))
      low_cnt_reg <= '0;
    else if (low_cnt_reg < 32'(TIMEOUT_CYCLES))
      low_cnt_reg <= low_cnt_reg + 32'd1;
  end
  assign time_out = low_cnt_reg == 32'(TIMEOUT_CYCLES);
  // read mux; reserved codes and codes past the end read zero
  always_comb
  begin
    unique case (code_reg)
      CODE_CONFIG_PRIMARY: rdata = config_primary;
      CODE_CONFIG_SECONDARY: rdata = config_secondary;
      CODE_UPPER_LOW: rdata = upper_lo;
      CODE_UPPER_HIGH: rdata = upper_hi;
      CODE_LOWER_LOW: rdata = lower_lo;
      CODE_LOWER_HIGH: rdata = lower_hi;
      CODE_VISIBLE_LOW: rdata = visible_reg[7:0];
      CODE_VISIBLE_HIGH: rdata = visible_reg[15:8];
      CODE_INFRARED_LOW: rdata = infrared_reg[7:0];
      CODE_INFRARED_HIGH: rdata = infrared_reg[15:8];
      CODE_PART_LOW: rdata = PART_LOW;
      CODE_PART_HIGH: rdata = PART_HIGH;
      CODE_EVENT_FLAGS: rdata = events_reg & EVENT_MASK;
      default: rdata = RST_ZERO;
    endcase
  end
  // protocol engine
  always_ff @(posedge clk)
  begin
    if (sys_rst || time_out || stop_det)
    begin
      state_reg <= LSI_IDLE;
      sda_oe_n_reg <= 1'b1;
      bit_reg <= '0;
      shift_reg <= '0;
      rw_reg <= 1'b0;
      have_code_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= LSI_ADDR;
      sda_oe_n_reg <= 1'b1;
      bit_reg <= '0;
      have_code_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        LSI_IDLE:
          sda_oe_n_reg <= 1'b1;
        LSI_ADDR, LSI_WRX:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_reg <= bit_reg + 4'd1;
          end
          else if (scl_fall && bit_reg == 4'd8)
          begin
            bit_reg <= '0;
            if (state_reg == LSI_ADDR)
            begin
              rw_reg <= shift_reg[0];
              sda_oe_n_reg <= shift_reg[7:1] != my_addr;
              state_reg <= shift_reg[7:1] == my_addr ? LSI_ACK : LSI_IDLE;
            end
            else
            begin
              sda_oe_n_reg <= 1'b0;
              have_code_reg <= 1'b1;
              state_reg <= LSI_ACK;
            end
          end
        end
        LSI_ACK:
          if (scl_fall)
          begin
            // reads keep working in shutdown
            if (rw_reg)
            begin
              state_reg <= LSI_RDX;
              sda_oe_n_reg <= rdata[7];
              shift_reg <= {rdata[6:0], 1'b0};
              bit_reg <= 4'd1;
            end
            else
            begin
              state_reg <= LSI_WRX;
              sda_oe_n_reg <= 1'b1;
            end
          end
        LSI_RDX:
          if (scl_fall)
          begin
            if (bit_reg == 4'd8)
            begin
              sda_oe_n_reg <= 1'b1;
              state_reg <= LSI_RACK;
            end
            else
            begin
              sda_oe_n_reg <= shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_reg <= bit_reg + 4'd1;
            end
          end
        LSI_RACK:
          if (scl_rise)
            state_reg <= sda_s ? LSI_IDLE : LSI_ACK;
      endcase
    end
  end
  // command code and auto-increment for word transfers
  logic wr_byte, rd_next, code_byte;
  assign wr_byte = state_reg == LSI_WRX && scl_fall && bit_reg == 4'd8 && !start_det;
  assign code_byte = wr_byte && !have_code_reg;
  assign rd_next = state_reg == LSI_RACK && scl_rise && !sda_s;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      code_reg <= '0;
    else if (code_byte)
      code_reg <= shift_reg;
    else if ((wr_byte && have_code_reg) || rd_next)
      code_reg <= code_reg + 8'd1;
  end
  // writable registers; only defined writable codes take data
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      config_primary <= RST_CONFIG_PRIMARY;
      config_secondary <= RST_ZERO;
      upper_lo <= RST_ZERO;
      upper_hi <= RST_ZERO;
      lower_lo <= RST_ZERO;
      lower_hi <= RST_ZERO;
    end
    else if (wr_byte && have_code_reg)
    begin
      unique case (code_reg)
        CODE_CONFIG_PRIMARY: config_primary <= shift_reg;
        CODE_CONFIG_SECONDARY: config_secondary <= shift_reg;
        CODE_UPPER_LOW: upper_lo <= shift_reg;
        CODE_UPPER_HIGH: upper_hi <= shift_reg;
        CODE_LOWER_LOW: lower_lo <= shift_reg;
        CODE_LOWER_HIGH: lower_hi <= shift_reg;
        default: ;
      endcase
    end
  end
  assign core_power_down = config_primary[BIT_CORE_POWER_DOWN];
  assign channel_power_down = config_secondary[BIT_CHANNEL_POWER_DOWN];
  // results latch only while running; shutdown keeps the last value
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      visible_reg <= '0;
      infrared_reg <= '0;
    end
    else if (result_valid && !core_power_down && !channel_power_down)
    begin
      visible_reg <= visible_in;
      infrared_reg <= infrared_in;
    end
  end
  // event flags: set wins over clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      events_reg <= RST_ZERO;
    else
    begin
      for (int i = 0; i < 3; i++)
        if (event_set[i])
          events_reg[i + 1] <= 1'b1;
        else if (event_clear)
          events_reg[i + 1] <= 1'b0;
    end
  end
  assign bus.sda_oe_n_dev = sda_oe_n_reg;
  assign bus.int_oe_n_dev = !int_request;
endmodule

// *** core/lsi_host.sv ***
// file: host end, I2C controller ordered over classic Wishbone
// assumes a single target on the bus, word register transfers only
`timescale 1ns/1ps
module lsi_host
  import lsi_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = ADDR_VARIANT_A,
  parameter int QUARTER = QUARTER_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // bus
  lsi_bus_if.host bus
);
  import lsi_pkg::*;
  typedef enum {LSH_IDLE, LSH_START, LSH_BIT, LSH_RESTART, LSH_STOP} lsi_hstate_e;
  lsi_hstate_e state_reg;
  logic [1:0] pin_sync;
  logic sda_s, int_s, busy_reg, nack_reg, rd_reg, scl_reg, sda_reg;
  logic [7:0] code_reg;
  logic [15:0] wdata_reg, rdata_reg;
  logic [7:0] tx_reg;
  logic [3:0] bit_reg;
  logic [2:0] byte_reg;
  logic [1:0] phase_reg;
  logic [15:0] tick_reg;
  logic tick, go;
  lsi_sync #(.WIDTH(2)) u_sync (.clk(clk), .sys_rst(sys_rst),
    .async_in({bus.sda, bus.int_line}), .sync_out(pin_sync));
  assign sda_s = pin_sync[1];
  assign int_s = pin_sync[0];
  // wishbone: ack one cycle after the strobe, dropped the next cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end
  assign go = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == WB_CTRL
              && wb_sel_i[0] && !busy_reg;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wb_dat_o <= '0;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      unique case (wb_adr_i)
        WB_STATUS: wb_dat_o <= {29'd0, int_s, nack_reg, busy_reg};
        WB_DATA: wb_dat_o <= {16'd0, rdata_reg};
        default: wb_dat_o <= '0;
      endcase
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tick_reg <= '0;
    else
      tick_reg <= tick ? '0 : tick_reg + 16'd1;
  end
  assign tick = tick_reg == 16'(QUARTER - 1);
  // byte sequence: addr-w, code, then lo, hi (write) or addr-r, lo, hi (read)
  function automatic logic [7:0] next_byte(input logic [2:0] n);
    unique case (n)
      3'd0: next_byte = {TARGET_ADDR, 1'b0};
      3'd1: next_byte = code_reg;
      3'd2: next_byte = rd_reg ? {TARGET_ADDR, 1'b1} : wdata_reg[7:0];
      3'd3: next_byte = rd_reg ? 8'hFF : wdata_reg[15:8];
      default: next_byte = 8'hFF;
    endcase
  endfunction
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= LSH_IDLE;
      busy_reg <= 1'b0;
      nack_reg <= 1'b0;
      rd_reg <= 1'b0;
      code_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      tx_reg <= '0;
      bit_reg <= '0;
      byte_reg <= '0;
      phase_reg <= '0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end
    else if (go)
    begin
      busy_reg <= 1'b1;
      nack_reg <= 1'b0;
      rd_reg <= wb_dat_i[24];
      code_reg <= wb_dat_i[23:16];
      wdata_reg <= wb_dat_i[15:0];
      byte_reg <= '0;
      phase_reg <= '0;
      state_reg <= LSH_START;
    end
    else if (tick)
    begin
      phase_reg <= phase_reg + 2'd1;
      unique case (state_reg)
        LSH_IDLE:
          phase_reg <= '0;
        LSH_START, LSH_RESTART:
          unique case (phase_reg)
            2'd0: sda_reg <= 1'b1;
            2'd1: scl_reg <= 1'b1;
            2'd2: sda_reg <= 1'b0;
            2'd3:
            begin
              scl_reg <= 1'b0;
              tx_reg <= next_byte(byte_reg);
              bit_reg <= '0;
              state_reg <= LSH_BIT;
            end
          endcase
        LSH_BIT:
          unique case (phase_reg)
            2'd0: sda_reg <= bit_reg == 4'd8 ? !(rd_reg && byte_reg == 3'd3) : tx_reg[7];
            2'd1: scl_reg <= 1'b1;
            2'd2:
              if (bit_reg == 4'd8)
              begin
                if (sda_s && !(rd_reg && byte_reg >= 3'd3))
                  nack_reg <= 1'b1;
              end
              else if (rd_reg && byte_reg >= 3'd3)
                rdata_reg <= byte_reg == 3'd3 ? {rdata_reg[15:8], rdata_reg[6:0], sda_s}
                                              : {rdata_reg[14:8], sda_s, rdata_reg[7:0]};
            2'd3:
            begin
              scl_reg <= 1'b0;
              tx_reg <= {tx_reg[6:0], 1'b1};
              bit_reg <= bit_reg + 4'd1;
              if (bit_reg == 4'd8)
              begin
                byte_reg <= byte_reg + 3'd1;
                bit_reg <= '0;
                tx_reg <= next_byte(byte_reg + 3'd1);
                if (nack_reg || byte_reg == 3'd4 || (!rd_reg && byte_reg == 3'd3))
                  state_reg <= LSH_STOP;
                else if (rd_reg && byte_reg == 3'd1)
                  state_reg <= LSH_RESTART;
              end
            end
          endcase
        LSH_STOP:
          unique case (phase_reg)
            2'd0: sda_reg <= 1'b0;
            2'd1: scl_reg <= 1'b1;
            2'd2: sda_reg <= 1'b1;
            2'd3:
            begin
              busy_reg <= 1'b0;
              state_reg <= LSH_IDLE;
            end
          endcase
      endcase
    end
  end
  assign bus.scl_oe_n_host = scl_reg;
  assign bus.sda_oe_n_host = sda_reg;
endmodule

// *** tb/lsi_bus_assertions.sv ***
// checker: sensor-end behaviour on the first two-wire bus
// assumes wire levels and the sensor's data enable, one clock domain
`timescale 1ns/1ps
module lsi_bus_assertions
  import lsi_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = ADDR_VARIANT_A,
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_n_dev
);
  logic scl_q, sda_q, busy_reg, rd_reg;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] shift_reg;
  logic [31:0] low_cnt;
  wire rise = scl & ~scl_q;
  wire start_det = scl & scl_q & sda_q & ~sda;
  wire stop_det = scl & scl_q & ~sda_q & sda;
  wire ack_slot = rise & (bit_cnt == 4'h8);
  wire addr_hit = shift_reg[7:1] == DEV_ADDR;
  always_ff @(posedge clk)
  begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // bit and byte position within a transfer
  always_ff @(posedge clk)
  begin
    if (sys_rst || start_det)
    begin
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
    end
    else if (ack_slot)
    begin
      bit_cnt <= 4'h0;
      if (byte_idx != 2'h3)
        byte_idx <= byte_idx + 2'h1;
    end
    else if (rise)
    begin
      bit_cnt <= bit_cnt + 4'h1;
      shift_reg <= {shift_reg[6:0], sda};
    end
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst || stop_det)
      busy_reg <= 1'b0;
    else if (start_det)
      busy_reg <= 1'b1;
    if (ack_slot && byte_idx == 2'h0)
      rd_reg <= shift_reg[0];
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst || scl)
      low_cnt <= 32'h0;
    else if (low_cnt != 32'hFFFF_FFFF)
      low_cnt <= low_cnt + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_addr_ack;
    ack_slot && byte_idx == 2'h0 && addr_hit |-> !sda_oe_n_dev [*8];
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");
  property p_addr_ignore;
    ack_slot && byte_idx == 2'h0 && !addr_hit |-> sda_oe_n_dev [*8];
  endproperty
  a_addr_ignore: assert property (p_addr_ignore)
    else $error("foreign address acknowledged");
  property p_write_release;
    ack_slot && byte_idx == 2'h0 && addr_hit && !shift_reg[0] |-> ##[1:40] sda_oe_n_dev;
  endproperty
  a_write_release: assert property (p_write_release)
    else $error("data line kept after write address");
  property p_code_ack;
    ack_slot && byte_idx == 2'h1 && !rd_reg |-> !sda_oe_n_dev;
  endproperty
  a_code_ack: assert property (p_code_ack)
    else $error("command byte not acknowledged");
  property p_read_release;
    ack_slot && byte_idx != 2'h0 && rd_reg |-> sda_oe_n_dev && $stable(sda_oe_n_dev);
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("sensor drives the host acknowledge slot");
  property p_data_hold;
    scl && scl_q |-> $stable(sda_oe_n_dev);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("sensor data changed while clock high");
  property p_idle_release;
    !busy_reg |-> sda_oe_n_dev;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("sensor drives an idle bus");
  property p_start_release;
    start_det |-> sda_oe_n_dev [*3];
  endproperty
  a_start_release: assert property (p_start_release)
    else $error("sensor drives data at a start");
  property p_timeout;
    low_cnt > 32'(TIMEOUT_CYCLES + 16) |-> sda_oe_n_dev;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("bus not released after clock low timeout");
endmodule

// *** tb/lsi_tb_top.sv ***
// testbench: three host and sensor pairs driven over wishbone
// assumes pair 0 and 1 matched, pair 2 host aims at a foreign address
`timescale 1ns/1ps
module lsi_tb_top;
  import lsi_pkg::*;
  localparam int NP = 3;
  localparam int TMO = 2000;
  localparam logic [6:0] TGT [NP] = '{ADDR_VARIANT_A, ADDR_VARIANT_B, ADDR_VARIANT_B};
  localparam bit VAR [NP] = '{1'b0, 1'b1, 1'b0};
  localparam logic [7:0] PART_L = 8'h5C; // arbitrary identity value
  localparam logic [7:0] PART_H = 8'h3A; // arbitrary identity value
  localparam logic [7:0] WCODES [8] = '{8'h00, 8'h04, 8'h06, 8'h10, 8'h08, 8'h14, 8'h07, 8'h16};
  logic clk, sys_rst, result_valid, event_clear, int_request;
  logic [15:0] visible_in, infrared_in;
  logic [2:0] event_set;
  logic wb_cyc [NP], wb_stb [NP], wb_we [NP], wb_ack [NP], core_pd [NP], chan_pd [NP];
  logic [3:0] wb_adr [NP];
  logic [31:0] wb_wdat [NP], wb_rdat [NP];
  logic [7:0] cfg_p [NP], cfg_s [NP], mdl [24];
  int num_errors = 0;
  int n_checks = 0;
  int seed = 32'h02ba;
  lsi_bus_if bus_if [NP] ();
  for (genvar g = 0; g < NP; g++)
  begin : g_pair
    lsi_host #(.TARGET_ADDR(TGT[g]), .QUARTER(10)) u_lsi_host (.clk(clk), .sys_rst(sys_rst),
      .wb_cyc_i(wb_cyc[g]), .wb_stb_i(wb_stb[g]), .wb_we_i(wb_we[g]), .wb_adr_i(wb_adr[g]),
      .wb_sel_i(4'hF), .wb_dat_i(wb_wdat[g]), .wb_dat_o(wb_rdat[g]), .wb_ack_o(wb_ack[g]),
      .bus(bus_if[g]));
    lsi_sensor #(.ADDR_VARIANT(VAR[g]), .TIMEOUT_CYCLES(TMO), .PART_LOW(PART_L),
      .PART_HIGH(PART_H)) u_lsi_sensor (.clk(clk), .sys_rst(sys_rst), .bus(bus_if[g]),
      .result_valid(result_valid), .visible_in(visible_in), .infrared_in(infrared_in),
      .event_set(event_set), .event_clear(event_clear), .int_request(int_request),
      .core_power_down(core_pd[g]), .channel_power_down(chan_pd[g]),
      .config_primary(cfg_p[g]), .config_secondary(cfg_s[g]));
  end
  lsi_bus_assertions #(.DEV_ADDR(ADDR_VARIANT_A), .TIMEOUT_CYCLES(TMO)) u_lsi_bus_assertions (
    .clk(clk), .sys_rst(sys_rst), .scl(bus_if[0].scl), .sda(bus_if[0].sda),
    .sda_oe_n_dev(bus_if[0].sda_oe_n_dev));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wb_xfer(input int i, input logic we, input logic [3:0] adr,
                         input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    wb_cyc[i] <= 1'b1;
    wb_stb[i] <= 1'b1;
    wb_we[i] <= we;
    wb_adr[i] <= adr;
    wb_wdat[i] <= d;
    @(posedge clk);
    while (wb_ack[i] !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    q = wb_rdat[i];
    wb_cyc[i] <= 1'b0;
    wb_stb[i] <= 1'b0;
    if (n == 50)
    begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic i2c_op(input int i, input logic rd, input logic [7:0] code,
                        input logic [15:0] wd, output logic [15:0] rw, output logic nk);
    logic [31:0] q = 32'h1;
    int n = 0;
    wb_xfer(i, 1'b1, WB_CTRL, {7'h00, rd, code, wd}, q);
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 3000)
    begin
      wb_xfer(i, 1'b0, WB_STATUS, 32'h0, q);
      n++;
    end
    nk = q[1];
    wb_xfer(i, 1'b0, WB_DATA, 32'h0, q);
    rw = q[15:0];
    if (n == 3000)
    begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic rd_word(input int i, input logic [7:0] code, output logic [15:0] w);
    logic nk;
    i2c_op(i, 1'b1, code, 16'h0, w, nk);
    check("read nack", {31'h0, nk}, 32'h0);
  endtask
  task automatic sweep(input int last);
    logic [15:0] w;
    for (int c = 0; c < last; c += 2)
    begin
      rd_word(0, 8'(c), w);
      check($sformatf("code %0h", c), {16'h0, w}, {16'h0, mdl[c+1], mdl[c]});
    end
  endtask
  function automatic logic writable(input int c);
    return c <= 7 && c != 2 && c != 3;
  endfunction
  task automatic pulse_result(input logic [15:0] v, input logic [15:0] r);
    @(posedge clk);
    result_valid <= 1'b1;
    visible_in <= v;
    infrared_in <= r;
    @(posedge clk);
    result_valid <= 1'b0;
  endtask
  task automatic check_results(input logic [15:0] v, input logic [15:0] r);
    logic [15:0] w;
    rd_word(0, CODE_VISIBLE_LOW, w);
    check("visible", {16'h0, w}, {16'h0, v});
    rd_word(0, CODE_INFRARED_LOW, w);
    check("infrared", {16'h0, w}, {16'h0, r});
  endtask
  initial
  begin
    logic [15:0] w, wd, v, r;
    logic [31:0] q;
    logic [7:0] ev = 8'h00;
    logic nk;
    sys_rst = 1'b1;
    {result_valid, event_clear, int_request, visible_in, infrared_in, event_set} = '0;
    for (int k = 0; k < NP; k++)
    begin
      {wb_cyc[k], wb_stb[k], wb_we[k], wb_adr[k], wb_wdat[k]} = '0;
    end
    for (int k = 0; k < 24; k++)
      mdl[k] = 8'h00;
    mdl[0] = RST_CONFIG_PRIMARY;
    mdl[20] = PART_L;
    mdl[21] = PART_H;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    sweep(24);
    check("core power down", {31'h0, core_pd[0]}, 32'h1);
    $display("test reset values done");
    for (int k = 0; k < 8; k++)
    begin
      wd = 16'($random(seed));
      i2c_op(0, 1'b0, WCODES[k], wd, w, nk);
      if (writable(WCODES[k]))
        mdl[WCODES[k]] = wd[7:0];
      if (writable(WCODES[k] + 1))
        mdl[WCODES[k] + 1] = wd[15:8];
    end
    sweep(8);
    check("primary out", {24'h0, cfg_p[0]}, {24'h0, mdl[0]});
    check("secondary out", {24'h0, cfg_s[0]}, {24'h0, mdl[1]});
    check("channel down", {31'h0, chan_pd[0]}, {31'h0, mdl[1][7]});
    $display("test register writes done");
    i2c_op(0, 1'b0, CODE_CONFIG_PRIMARY, 16'h0000, w, nk);
    v = 16'($random(seed));
    r = 16'($random(seed));
    pulse_result(v, r);
    check_results(v, r);
    for (int s = 0; s < 2; s++)
    begin
      i2c_op(0, 1'b0, CODE_CONFIG_PRIMARY, s == 0 ? 16'h0001 : 16'h8000, w, nk);
      pulse_result(~v, ~r);
      check_results(v, r);
    end
    $display("test shutdown retention done");
    for (int b = 0; b < 3; b++)
    begin
      @(posedge clk);
      event_set <= 3'(1 << b);
      @(posedge clk);
      event_set <= 3'h0;
      ev = ev | (8'h02 << b);
      rd_word(0, CODE_EVENT_FLAGS, w);
      check("event flags", {24'h0, w[7:0]}, {24'h0, ev});
    end
    @(posedge clk);
    event_clear <= 1'b1;
    event_set <= 3'h4;
    @(posedge clk);
    event_clear <= 1'b0;
    event_set <= 3'h0;
    rd_word(0, CODE_EVENT_FLAGS, w);
    check("set over clear", {24'h0, w[7:0]}, 32'h8);
    @(posedge clk);
    event_clear <= 1'b1;
    @(posedge clk);
    event_clear <= 1'b0;
    rd_word(0, CODE_EVENT_FLAGS, w);
    check("event cleared", {24'h0, w[7:0]}, 32'h0);
    $display("test events done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      int_request <= k[0];
      repeat (3) @(posedge clk);
      wb_xfer(0, 1'b0, WB_STATUS, 32'h0, q);
      check("interrupt status", {31'h0, q[2]}, {31'h0, ~k[0]});
      check("interrupt wire", {31'h0, bus_if[0].int_line}, {31'h0, ~k[0]});
    end
    wb_xfer(0, 1'b1, 4'hC, 32'hFFFF_FFFF, q);
    wb_xfer(0, 1'b0, 4'hC, 32'h0, q);
    check("unmapped", q, 32'h0);
    $display("test interrupt and bus done");
    rd_word(1, CODE_PART_LOW, w);
    check("second address", {16'h0, w}, {16'h0, PART_H, PART_L});
    i2c_op(2, 1'b1, CODE_PART_LOW, 16'h0, w, nk);
    check("foreign address", {31'h0, nk}, 32'h1);
    $display("test address variants done");
    conclude();
  end
endmodule
